// ===== rtl/ssq_pkg.sv
/*
  Constants of the stepper phase sequencer: register map, field positions,
  reset values and timing counts.
  Assumes a 100 MHz pclk and a 32-bit APB register bus.
*/
// Behaviour
// - advance one step per step-clock rising edge only
// - mode low two-phase, high one-two phase
// - direction low forward, high reverse order
// - reset input low holds sequence, outputs off
// - reset release enters winding1_pos plus winding2_neg
// - sequence starts from first gate, continues after
// - mode sampled on step-clock rising edge
package ssq_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] SSQ_OFS_CTRL = 8'h00;
  localparam logic [7:0] SSQ_OFS_STATUS = 8'h04;
  localparam logic [7:0] SSQ_OFS_STEPS = 8'h08;

  // ==========================================================
  // control fields
  localparam int SSQ_CTRL_OUT_EN = 0;
  localparam int SSQ_CTRL_SOFT_RST = 1;
  localparam logic SSQ_CTRL_OUT_EN_RST = 1'b1;

  // ==========================================================
  // status fields
  localparam int SSQ_ST_PHASE_LSB = 0;
  localparam int SSQ_ST_INDEX_LSB = 4;
  localparam int SSQ_ST_MODE = 7;
  localparam int SSQ_ST_IN_RESET = 8;
  localparam int SSQ_ST_SHORT_RST = 9;

  // ==========================================================
  // sequence: index 0 is winding1_pos plus winding2_neg
  localparam logic [2:0] SSQ_INDEX_INIT = 3'h0;
  localparam int SSQ_STEP_CNT_W = 16;

  // ==========================================================
  // timing
  localparam int SSQ_CLK_PERIOD_NS = 10;
  localparam int SSQ_RESET_MIN_NS = 20000;
  localparam int SSQ_RESET_MIN_CYC =
    (SSQ_RESET_MIN_NS + SSQ_CLK_PERIOD_NS - 1) / SSQ_CLK_PERIOD_NS;
  localparam int SSQ_RST_CNT_W = 12;
endpackage

// ===== rtl/ssq_reg_if.sv
/*
  Signals between the register slave and the sequencer core.
  Assumes both ends run on pclk.
*/
`timescale 1ns/10ps
interface ssq_reg_if;
  logic out_enable;
  logic soft_reset;
  logic short_reset_clr;
  logic [3:0] phase;
  logic [2:0] index;
  logic mode_latched;
  logic in_reset;
  logic short_reset;
  logic [15:0] step_count;

  // register side drives control, reads state
  modport regs (
    output out_enable, soft_reset, short_reset_clr,
    input phase, index, mode_latched, in_reset, short_reset, step_count
  );
  // core side
  modport core (
    input out_enable, soft_reset, short_reset_clr,
    output phase, index, mode_latched, in_reset, short_reset, step_count
  );
endinterface

// ===== rtl/ssq_apb_regs.sv
/*
  APB slave with the control, status and step-count registers.
  Assumes APB3 signalling on pclk; one access cycle, never waits.
*/
`timescale 1ns/10ps
module ssq_apb_regs (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core
  ssq_reg_if.regs rif
);
  import ssq_pkg::*;

  logic out_enable;
  logic soft_reset;
  logic short_clr;

  // ==========================================================
  // decode
  wire setup = psel & ~penable;
  wire commit = psel & penable & pready;
  wire hit_ctrl = (paddr == SSQ_OFS_CTRL);
  wire hit_status = (paddr == SSQ_OFS_STATUS);
  wire hit_steps = (paddr == SSQ_OFS_STEPS);
  wire mapped = hit_ctrl | hit_status | hit_steps;
  wire [31:0] ctrl_word = {30'h0, 1'b0, out_enable};
  wire [31:0] status_word = {22'h0, rif.short_reset, rif.in_reset,
                             rif.mode_latched, rif.index, rif.phase};
  wire [31:0] steps_word = {16'h0, rif.step_count};
  wire [31:0] read_mux = hit_ctrl ? ctrl_word :
                         hit_status ? status_word :
                         hit_steps ? steps_word : 32'h0;

  // answer prepared in setup so the access cycle completes at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= (setup & ~pwrite) ? read_mux : 32'h0;
    end
  end

  // writes take effect only on the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_enable <= SSQ_CTRL_OUT_EN_RST;
      soft_reset <= 1'b0;
      short_clr <= 1'b0;
    end else begin
      if (commit && pwrite && hit_ctrl) begin
        out_enable <= pwdata[SSQ_CTRL_OUT_EN];
      end
      soft_reset <= commit & pwrite & hit_ctrl & pwdata[SSQ_CTRL_SOFT_RST];
      short_clr <= commit & pwrite & hit_status & pwdata[SSQ_ST_SHORT_RST];
    end
  end

  assign rif.out_enable = out_enable;
  assign rif.soft_reset = soft_reset;
  assign rif.short_reset_clr = short_clr;
endmodule

// ===== rtl/ssq_top.sv
/*
  Phase sequencer of a unipolar two-phase stepper driver with an APB
  register window.
  Assumes step_clock, mode_select, direction_select and reset_low_in are
  already synchronous to pclk; noise filtering is done outside.
*/
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/10ps
module ssq_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // host control pins
  input wire logic step_clock,
  input wire logic mode_select,
  input wire logic direction_select,
  input wire logic reset_low_in,
  // winding phase outputs
  output logic winding1_pos,
  output logic winding1_neg,
  output logic winding2_pos,
  output logic winding2_neg
);
  import ssq_pkg::*;

  ssq_reg_if rif ();

  ssq_apb_regs u_regs (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .rif(rif)
  );

  logic step_prev;
  logic [2:0] index;
  logic mode_latched;
  logic reset_prev;
  logic [SSQ_RST_CNT_W-1:0] reset_cnt;
  logic short_reset;
  logic [SSQ_STEP_CNT_W-1:0] step_count;
  logic [2:0] next_index;
  logic [3:0] next_phase;

  // ==========================================================
  // stepping decisions
  // step_prev resets high: a clock already high at release is no edge
  wire step_rise = step_clock & ~step_prev;
  wire hold_reset = ~reset_low_in | rif.soft_reset;
  wire on_half = index[0];
  // two-phase from a one-phase state moves one to rejoin the even states
  wire [2:0] stride = (mode_select && !on_half) ? 3'h1 :
                      (mode_select) ? 3'h1 :
                      (on_half ? 3'h1 : 3'h2);
  wire [2:0] fwd_index = index + stride;
  wire [2:0] rev_index = index - stride;

  // next position; reset always returns to the first gate state
  always_comb begin
    next_index = index;
    if (hold_reset) begin
      next_index = SSQ_INDEX_INIT;
    end else if (step_rise) begin
      next_index = direction_select ? rev_index : fwd_index;
    end
  end

  // phase pattern of the next position: {w1_pos, w1_neg, w2_pos, w2_neg}
  always_comb begin
    unique case (next_index)
      3'h0: next_phase = 4'b1001;
      3'h1: next_phase = 4'b1000;
      3'h2: next_phase = 4'b1010;
      3'h3: next_phase = 4'b0010;
      3'h4: next_phase = 4'b0110;
      3'h5: next_phase = 4'b0100;
      3'h6: next_phase = 4'b0101;
      3'h7: next_phase = 4'b0001;
    endcase
  end

  // ==========================================================
  // sequence state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_prev <= 1'b1;
      index <= SSQ_INDEX_INIT;
      mode_latched <= 1'b0;
    end else begin
      step_prev <= step_clock;
      index <= next_index;
      if (hold_reset) begin
        mode_latched <= 1'b0;
      end else if (step_rise) begin
        mode_latched <= mode_select;
      end
    end
  end

  // outputs cut off during reset or when software disables them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      winding1_pos <= 1'b0;
      winding1_neg <= 1'b0;
      winding2_pos <= 1'b0;
      winding2_neg <= 1'b0;
    end else if (hold_reset || !rif.out_enable) begin
      winding1_pos <= 1'b0;
      winding1_neg <= 1'b0;
      winding2_pos <= 1'b0;
      winding2_neg <= 1'b0;
    end else begin
      winding1_pos <= next_phase[3];
      winding1_neg <= next_phase[2];
      winding2_pos <= next_phase[1];
      winding2_neg <= next_phase[0];
    end
  end

  // ==========================================================
  // reset width watch: host must hold reset long enough
  wire reset_release = reset_low_in & ~reset_prev;
  wire cnt_full = (reset_cnt == SSQ_RST_CNT_W'(SSQ_RESET_MIN_CYC));
  wire short_set = reset_release & ~cnt_full;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_prev <= 1'b1;
      reset_cnt <= '0;
      short_reset <= 1'b0;
    end else begin
      reset_prev <= reset_low_in;
      if (reset_low_in) begin
        reset_cnt <= '0;
      end else if (!cnt_full) begin
        reset_cnt <= reset_cnt + 1'b1;
      end
      // a new event wins over a clear in the same cycle
      if (short_set) begin
        short_reset <= 1'b1;
      end else if (rif.short_reset_clr) begin
        short_reset <= 1'b0;
      end
    end
  end

  // ==========================================================
  // steps taken since the last reset, wraps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_count <= '0;
    end else if (hold_reset) begin
      step_count <= '0;
    end else if (step_rise) begin
      step_count <= step_count + 1'b1;
    end
  end

  assign rif.phase = {winding1_pos, winding1_neg, winding2_pos, winding2_neg};
  assign rif.index = index;
  assign rif.mode_latched = mode_latched;
  assign rif.in_reset = ~reset_low_in;
  assign rif.short_reset = short_reset;
  assign rif.step_count = step_count;
endmodule

// ===== sim/ssq_chk.sv
/* Port assertions of ssq_top.
   Bound in from tb_top; sees top ports only. */
`timescale 1ns/10ps
module ssq_chk (
  // clock, reset, apb answer
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // host pins and phases
  input wire logic step_clock,
  input wire logic mode_select,
  input wire logic direction_select,
  input wire logic reset_low_in,
  input wire logic winding1_pos,
  input wire logic winding1_neg,
  input wire logic winding2_pos,
  input wire logic winding2_neg
);
  // ==========
  // phase word w1p w1n w2p w2n; forward half-step table, index 0 low
  wire logic [3:0] ph = {winding1_pos, winding1_neg, winding2_pos, winding2_neg};
  localparam logic [31:0] SEQ = 32'h1546_2a89;
  // two-phase from a single-coil state takes one step to realign
  function automatic logic [3:0] adv(logic [3:0] p, logic rev, logic half);
    int n;
    n = (half || $countones(p) == 1) ? 1 : 2;
    for (int i = 0; i < 8; i++)
      if (SEQ[i*4+:4] == p) return SEQ[((rev ? i + 8 - n : i + n) % 8) * 4 +: 4];
    return 4'h0;
  endfunction
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========
  // step edge and reset release as seen on the pins
  sequence s_rise;
    (reset_low_in && !step_clock) ##1 (reset_low_in && step_clock);
  endsequence
  sequence s_release;
    !reset_low_in ##1 (reset_low_in && !step_clock);
  endsequence
  off_in_reset_a: assert property (!reset_low_in |=> ph == 4'h0)
    else $error("phases on during reset");
  init_state_a: assert property (s_release |=> ph == 4'h9)
    else $error("wrong state after release");
  hold_no_step_a: assert property (reset_low_in && $past(reset_low_in) &&
    !(step_clock && !$past(step_clock)) |=> $stable(ph)) else $error("phase moved");
  step_next_a: assert property (s_rise |=>
    ph == adv($past(ph), $past(direction_select), $past(mode_select)))
    else $error("wrong next phase");
  two_phase_a: assert property ((s_rise ##0 !mode_select) |=> $countones(ph) == 2)
    else $error("two-phase step left one coil");
  half_alt_a: assert property ((s_rise ##0 mode_select) |=>
    $countones(ph) != $countones($past(ph))) else $error("half step not alternating");
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  err_with_ready_a: assert property (pslverr |-> pready && psel && penable)
    else $error("stray slave error");
endmodule

// ===== sim/ssq_host.sv
/* Host controller model on the step pins.
   Tasks called from tb_top; pclk runs at 100 MHz. */
`timescale 1ns/10ps
module ssq_host (
  // clock
  input wire logic pclk,
  // step pins
  output logic step_clock,
  output logic mode_select,
  output logic direction_select,
  output logic reset_low_in
);
  // 20 us at 10 ns a cycle
  localparam int MIN_W = 2000;
  initial begin
    step_clock = 1'b0;
    mode_select = 1'b0;
    direction_select = 1'b0;
    reset_low_in = 1'b0;
  end
  // margin over the minimum keeps the short-reset flag clear;
  // a shorter width is asked for only to provoke that flag
  task automatic hold_reset(input int cyc = MIN_W + 100);
    reset_low_in <= 1'b0;
    repeat (cyc) @(posedge pclk);
    reset_low_in <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask
  // 20 us high, 20 us low: 25 kHz at most
  task automatic pulse(input logic mode, input logic dir);
    mode_select <= mode;
    direction_select <= dir;
    @(posedge pclk);
    step_clock <= 1'b1;
    repeat (MIN_W) @(posedge pclk);
    step_clock <= 1'b0;
    repeat (MIN_W) @(posedge pclk);
  endtask
endmodule

// ===== sim/tb_top.sv
/* Self-checking bench of ssq_top.
   Step pins from ssq_host; APB driven here. */
`timescale 1ns/10ps
module tb_top;
  import ssq_pkg::*;
  // ==========
  // signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, step_clock, mode_select, direction_select, reset_low_in;
  logic w1p, w1n, w2p, w2n;
  wire logic [3:0] ph = {w1p, w1n, w2p, w2n};
  int fails = 0;
  int check_count = 0;
  always #5 pclk = ~pclk;
  ssq_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .step_clock, .mode_select, .direction_select, .reset_low_in,
    .winding1_pos(w1p), .winding1_neg(w1n), .winding2_pos(w2p), .winding2_neg(w2n));
  ssq_host host (.pclk, .step_clock, .mode_select, .direction_select, .reset_low_in);
  // ==========
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // waits on pready with a bound; read data taken at that edge
  task automatic reg_read(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= 1'b0;
    paddr <= a;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    check({31'h0, pready}, 32'h1);
    check(prdata, exp);
    check({31'h0, pslverr}, {31'h0, eerr});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // write lands at the edge where pready is seen high
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= 1'b1;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    check({31'h0, pready}, 32'h1);
    check({31'h0, pslverr}, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    @(posedge pclk);
  endtask
  // each entry: mode, direction, landing phase
  task automatic walk(input logic [5:0] e);
    host.pulse(e[5], e[4]);
    check({28'h0, ph}, {28'h0, e[3:0]});
  endtask
  // ==========
  // scenarios
  task automatic t_reset();
    check({28'h0, ph}, 32'h0);
    host.hold_reset();
    check({28'h0, ph}, 32'h9);
    reg_read(SSQ_OFS_CTRL, 32'h1, 1'b0);
    reg_read(SSQ_OFS_STATUS, 32'h9, 1'b0);
    reg_read(8'h0c, 32'h0, 1'b1);
  endtask
  task automatic t_two();
    logic [5:0] tb [6] = '{6'h0a, 6'h06, 6'h05, 6'h09, 6'h15, 6'h16};
    foreach (tb[i]) walk(tb[i]);
  endtask
  task automatic t_half();
    logic [5:0] tb [7] = '{6'h24, 6'h25, 6'h21, 6'h29, 6'h31, 6'h35, 6'h34};
    foreach (tb[i]) walk(tb[i]);
    reg_read(SSQ_OFS_STATUS, 32'hd4, 1'b0);
  endtask
  // odd index in two-phase takes a single step
  task automatic t_switch();
    walk(6'h05);
    reg_read(SSQ_OFS_STATUS, 32'h65, 1'b0);
    reg_read(SSQ_OFS_STEPS, 32'he, 1'b0);
  endtask
  task automatic t_midreset();
    fork
      host.hold_reset();
      begin
        repeat (10) @(posedge pclk);
        check({28'h0, ph}, 32'h0);
        reg_read(SSQ_OFS_STATUS, 32'h100, 1'b0);
        // output gate toggled only while held, so phases stay off anyway
        reg_write(SSQ_OFS_CTRL, 32'h0);
        reg_read(SSQ_OFS_CTRL, 32'h0, 1'b0);
        reg_write(SSQ_OFS_CTRL, 32'h1);
        reg_read(SSQ_OFS_CTRL, 32'h1, 1'b0);
      end
    join
    check({28'h0, ph}, 32'h9);
    reg_read(SSQ_OFS_STEPS, 32'h0, 1'b0);
  endtask
  // too short a reset raises the sticky flag; write 1 clears it
  task automatic t_short();
    host.hold_reset(100);
    reg_read(SSQ_OFS_STATUS, 32'h209, 1'b0);
    reg_write(SSQ_OFS_STATUS, 32'h200);
    reg_read(SSQ_OFS_STATUS, 32'h9, 1'b0);
  endtask
  task automatic report_and_stop();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ==========
  // sequence and watchdog; run is about 60k cycles
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_two();
    t_half();
    t_switch();
    t_midreset();
    t_short();
    report_and_stop();
  end
  initial begin
    #900000;
    fails++;
    report_and_stop();
  end
endmodule
bind ssq_top ssq_chk u_chk (.*);
